// ---- logic/fca_pkg.sv ----
// shared constants for the fault capture and alert block
package fca_pkg;
	// clock and timing
	localparam int CLK_HZ = 40_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int NVM_SHORT_US = 700;
	localparam int NVM_LONG_US = 1400;
	localparam int NVM_SHORT_CYC = NVM_SHORT_US * CYC_PER_US;
	localparam int NVM_LONG_CYC = NVM_LONG_US * CYC_PER_US;
	localparam int BCAST_NS = 1000;
	localparam int BCAST_CYC = (BCAST_NS * CYC_PER_US) / 1000;
	localparam int SEQ_STEP_US = 100;
	localparam int SEQ_STEP_CYC = SEQ_STEP_US * CYC_PER_US;
	localparam int SYNC_GUARD = 3;
	localparam int TMR_W = 16;
	////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FRESP = 8'h04;
	localparam logic [7:0] OFS_SEQPOS = 8'h08;
	localparam logic [7:0] OFS_CAPCMD = 8'h0c;
	localparam logic [7:0] OFS_CAPDATA = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
	// control bit positions
	localparam int CTRL_RUN = 0;
	localparam int CTRL_CAP_EN = 1;
	localparam int CTRL_BCAST_EN = 2;
	localparam int CTRL_PEER_SHUT = 3;
	localparam int CTRL_RESTART = 4;
	localparam int CTRL_SHARE = 5;
	localparam int CTRL_BLOCK = 6;
	localparam int CTRL_W = 7;
	localparam logic [6:0] CTRL_RST = 7'h00;
	localparam logic [7:0] FRESP_RST = 8'hff;
	localparam logic [3:0] MASK_RST = 4'h0;
	// capture command values
	localparam logic [7:0] CMD_RECALL = 8'h01;
	localparam logic [7:0] CMD_STORE = 8'h02;
	// interrupt bit positions
	localparam int IRQ_LOCAL = 0;
	localparam int IRQ_PEER = 1;
	localparam int IRQ_NVM_DONE = 2;
	localparam int IRQ_REFUSED = 3;
	localparam int IRQ_W = 4;
	// capture record byte positions
	localparam int CAP_BYTES = 22;
	localparam int BYTE_VIN = 20;
	localparam int BYTE_VOUT = 18;
	localparam int BYTE_IAVG = 16;
	localparam int BYTE_IPEAK = 14;
	localparam int BYTE_DUTY = 12;
	localparam int BYTE_TINT = 10;
	localparam int BYTE_TEXT = 8;
	localparam int BYTE_FSW = 6;
	localparam int BYTE_ST_VOUT = 5;
	localparam int BYTE_ST_IOUT = 4;
	localparam int BYTE_ST_IN = 3;
	localparam int BYTE_ST_TEMP = 2;
	localparam int BYTE_ST_CML = 1;
	localparam int BYTE_ST_MFR = 0;
endpackage

// ---- logic/fca_sync.sv ----
`timescale 1ns/10ps
// two-flop synchroniser for pin inputs
module fca_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r; // first stage, read only by q
	////////////////////////////////////////////////////////////////
	// both stages idle high, the bus level at rest
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			meta_r <= '1;
			q <= '1;
		end
		else
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// ---- logic/fca_timer.sv ----
`timescale 1ns/10ps
// one-shot down counter: busy for count cycles, then a done pulse
module fca_timer #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic load,
	input wire logic [W-1:0] count,
	output logic busy,
	output logic done
);
	logic [W-1:0] cnt_r; // cycles left
	////////////////////////////////////////////////////////////////
	// load restarts the count; done fires as the last cycle ends
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cnt_r <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end
		else if (load)
		begin
			cnt_r <= count;
			busy <= 1'b1;
			done <= 1'b0;
		end
		else
		begin
			cnt_r <= (cnt_r > 1) ? cnt_r - 1'b1 : '0;
			busy <= busy && (cnt_r > 1);
			done <= busy && (cnt_r <= 1);
		end
	end
endmodule

// ---- logic/fca_top.sv ----
`timescale 1ns/10ps
// Operation
// RULE1: capture runs only when enable bit one set
// RULE2: record readable in operation and after fault
// RULE3: host block-reads all 22 record bytes
// RULE4: two-byte values at bytes 21 down to 6
// RULE5: status bytes fill bytes 5 down to 0
// RULE6: command one copies stored record into ram
// RULE7: command two stores record, output disabled only
// RULE8: shutdown fault stores record automatically
// RULE9: retry faults never store the record
// RULE10: store lasts 700 or 1400 us
// RULE11: host recalls first, then reads record
// RULE12: alert line pulled low on fault
// RULE13: host queries alert response address; no such address here, the host reads OFS_IRQ_STAT for the alert source
// RULE14: alert stays low until faults cleared
// RULE15: shutdown fault drops output and broadcasts
// RULE16: peer fault shuts down, restarts in order
// RULE17: share rail broadcasts only when all failed
// RULE18: share rail members restart together
// RULE19: capture disabled blocks stores and commands
module fca_top #(
	parameter int NF = 8,
	parameter int NVM_SHORT_CYC = fca_pkg::NVM_SHORT_CYC,
	parameter int NVM_LONG_CYC = fca_pkg::NVM_LONG_CYC,
	parameter int SEQ_STEP_CYC = fca_pkg::SEQ_STEP_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [NF-1:0] fault_req,
	input wire logic rail_others_up,
	input wire logic [15:0] mon_vin,
	input wire logic [15:0] mon_vout,
	input wire logic [15:0] mon_iavg,
	input wire logic [15:0] mon_ipeak,
	input wire logic [15:0] mon_duty,
	input wire logic [15:0] mon_tint,
	input wire logic [15:0] mon_text,
	input wire logic [15:0] mon_fsw,
	input wire logic [7:0] mon_st_vout,
	input wire logic [7:0] mon_st_iout,
	input wire logic [7:0] mon_st_in,
	input wire logic [7:0] mon_st_temp,
	input wire logic [7:0] mon_st_cml,
	input wire logic [7:0] mon_st_mfr,
	input wire logic interdevice_bus_in,
	output logic interdevice_bus_out,
	output logic interdevice_bus_oe_n,
	output logic fault_alert_line_out,
	output logic fault_alert_line_oe_n,
	output logic out_enable,
	output logic irq
);
	localparam int NB = fca_pkg::CAP_BYTES;
	localparam int BW = fca_pkg::TMR_W;
	localparam logic [BW-1:0] BC_WIN = BW'(fca_pkg::BCAST_CYC + fca_pkg::SYNC_GUARD);
	localparam logic [BW-1:0] BC_GUARD = BW'(fca_pkg::SYNC_GUARD);
	localparam logic [4:0] LAST_BYTE = 5'(NB - 1);
	////////////////////////////////////////////////////////////////
	// registers
	logic [fca_pkg::CTRL_W-1:0] ctrl_r; // control bits
	logic [NF-1:0] fresp_r; // 1: shutdown response, 0: retry
	logic [2:0] seqpos_r; // sequencing position
	logic [fca_pkg::IRQ_W-1:0] irq_stat_r; // sticky events
	logic [fca_pkg::IRQ_W-1:0] irq_mask_r; // event enables
	logic [NF-1:0] fault_prev_r; // last fault levels
	logic shut_r; // output shut by a fault
	logic frozen_r; // ram record held
	logic bc_pend_r; // rail broadcast waiting
	logic [BW-1:0] bc_cnt_r; // broadcast window
	logic ddc_prev_r; // previous synced bus level
	logic rst_armed_r; // restart timer started
	logic [4:0] rd_ptr_r; // block read byte pointer
	logic [7:0] ram_r [NB]; // live capture record
	logic [7:0] nvm_r [NB]; // non-volatile copy
	logic [fca_pkg::IRQ_W-1:0] irq_stat_nxt;
	logic [31:0] rd_mux;
	logic [8*NB-1:0] live_w;
	////////////////////////////////////////////////////////////////
	// decode and event wires
	wire ctrl_run = ctrl_r[fca_pkg::CTRL_RUN];
	wire cap_en = ctrl_r[fca_pkg::CTRL_CAP_EN];
	wire bcast_en = ctrl_r[fca_pkg::CTRL_BCAST_EN];
	wire peer_shut_en = ctrl_r[fca_pkg::CTRL_PEER_SHUT];
	wire restart_en = ctrl_r[fca_pkg::CTRL_RESTART];
	wire share_member = ctrl_r[fca_pkg::CTRL_SHARE];
	wire block_mode = ctrl_r[fca_pkg::CTRL_BLOCK];
	wire wr_ctrl = reg_wr && (reg_addr == fca_pkg::OFS_CTRL);
	wire wr_fresp = reg_wr && (reg_addr == fca_pkg::OFS_FRESP);
	wire wr_seq = reg_wr && (reg_addr == fca_pkg::OFS_SEQPOS);
	wire wr_cmd = reg_wr && (reg_addr == fca_pkg::OFS_CAPCMD);
	wire wr_stat = reg_wr && (reg_addr == fca_pkg::OFS_IRQ_STAT);
	wire wr_mask = reg_wr && (reg_addr == fca_pkg::OFS_IRQ_MASK);
	wire rd_data = reg_rd && (reg_addr == fca_pkg::OFS_CAPDATA);
	wire [NF-1:0] fault_new = fault_req & ~fault_prev_r;
	wire local_shut = |(fault_new & fresp_r);
	wire nvm_busy;
	wire nvm_done;
	wire rst_busy;
	wire rst_done;
	wire ddc_s;
	wire blk_busy = (rd_ptr_r != 5'h00);
	wire cmd_recall = wr_cmd && cap_en && (reg_wdata[7:0] == fca_pkg::CMD_RECALL)
		&& !nvm_busy; // RULE6 RULE19
	wire cmd_store = wr_cmd && (reg_wdata[7:0] == fca_pkg::CMD_STORE);
	wire store_ok = cmd_store && cap_en && !out_enable && !nvm_busy; // RULE7 RULE19
	wire store_refused = cmd_store && cap_en && !store_ok;
	wire auto_store = local_shut && cap_en && !nvm_busy; // RULE8 RULE9 RULE19
	wire nvm_go = store_ok || auto_store;
	wire [BW-1:0] nvm_len = block_mode ? BW'(NVM_LONG_CYC) : BW'(NVM_SHORT_CYC); // RULE10
	wire bc_idle = (bc_cnt_r == '0);
	wire rail_down = !share_member || !rail_others_up; // RULE17
	wire bcast_go = bcast_en && (local_shut || bc_pend_r) && rail_down && bc_idle; // RULE15
	wire peer_ev = ddc_prev_r && !ddc_s && bc_idle;
	wire peer_shut = peer_ev && peer_shut_en; // RULE16
	// own broadcast window must be over before a restart may start
	wire rst_go = shut_r && restart_en && !rst_armed_r && !(|fault_req) && ddc_s
		&& bc_idle; // RULE18
	wire [BW-1:0] rst_len = share_member ? BW'(1)
		: BW'((int'(seqpos_r) + 1) * SEQ_STEP_CYC); // RULE16 RULE18
	wire live_upd = cap_en && !frozen_r && !nvm_busy && !blk_busy; // RULE1
	wire [fca_pkg::IRQ_W-1:0] irq_set = {store_refused, nvm_done, peer_ev, |fault_new};
	// mask as it stands after this edge, so the alert never lags a mask write
	wire [fca_pkg::IRQ_W-1:0] irq_mask_nxt = wr_mask ? reg_wdata[fca_pkg::IRQ_W-1:0]
		: irq_mask_r;
	////////////////////////////////////////////////////////////////
	// live record layout
	assign live_w[fca_pkg::BYTE_VIN*8 +: 16] = mon_vin; // RULE4
	assign live_w[fca_pkg::BYTE_VOUT*8 +: 16] = mon_vout;
	assign live_w[fca_pkg::BYTE_IAVG*8 +: 16] = mon_iavg;
	assign live_w[fca_pkg::BYTE_IPEAK*8 +: 16] = mon_ipeak;
	assign live_w[fca_pkg::BYTE_DUTY*8 +: 16] = mon_duty;
	assign live_w[fca_pkg::BYTE_TINT*8 +: 16] = mon_tint;
	assign live_w[fca_pkg::BYTE_TEXT*8 +: 16] = mon_text;
	assign live_w[fca_pkg::BYTE_FSW*8 +: 16] = mon_fsw;
	assign live_w[fca_pkg::BYTE_ST_VOUT*8 +: 8] = mon_st_vout; // RULE5
	assign live_w[fca_pkg::BYTE_ST_IOUT*8 +: 8] = mon_st_iout;
	assign live_w[fca_pkg::BYTE_ST_IN*8 +: 8] = mon_st_in;
	assign live_w[fca_pkg::BYTE_ST_TEMP*8 +: 8] = mon_st_temp;
	assign live_w[fca_pkg::BYTE_ST_CML*8 +: 8] = mon_st_cml;
	assign live_w[fca_pkg::BYTE_ST_MFR*8 +: 8] = mon_st_mfr;
	// set wins over write-one-to-clear
	assign irq_stat_nxt = (irq_stat_r & ~(wr_stat ? reg_wdata[fca_pkg::IRQ_W-1:0] : '0))
		| irq_set;
	////////////////////////////////////////////////////////////////
	// read mux; unmapped offsets read zero
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (reg_addr)
			fca_pkg::OFS_CTRL: rd_mux = 32'(ctrl_r);
			fca_pkg::OFS_FRESP: rd_mux = 32'(fresp_r);
			fca_pkg::OFS_SEQPOS: rd_mux = 32'(seqpos_r);
			fca_pkg::OFS_CAPDATA: rd_mux = 32'(ram_r[rd_ptr_r]); // RULE2 RULE3
			fca_pkg::OFS_STATUS: rd_mux = 32'({frozen_r, blk_busy, nvm_busy, shut_r, out_enable});
			fca_pkg::OFS_IRQ_STAT: rd_mux = 32'(irq_stat_r);
			fca_pkg::OFS_IRQ_MASK: rd_mux = 32'(irq_mask_r);
			default: rd_mux = 32'h0000_0000;
		endcase
	end
	////////////////////////////////////////////////////////////////
	// pin synchroniser and timers
	fca_sync #(.W(1)) u_ddc_sync (
		.clk(clk),
		.reset(reset),
		.d(interdevice_bus_in),
		.q(ddc_s)
	);
	fca_timer #(.W(BW)) u_nvm_tmr (
		.clk(clk),
		.reset(reset),
		.load(nvm_go),
		.count(nvm_len),
		.busy(nvm_busy),
		.done(nvm_done)
	);
	fca_timer #(.W(BW)) u_rst_tmr (
		.clk(clk),
		.reset(reset),
		.load(rst_go),
		.count(rst_len),
		.busy(rst_busy),
		.done(rst_done)
	);
	////////////////////////////////////////////////////////////////
	// software registers and bus answer
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ctrl_r <= fca_pkg::CTRL_RST;
			fresp_r <= NF'(fca_pkg::FRESP_RST);
			seqpos_r <= 3'h0;
			irq_stat_r <= '0;
			irq_mask_r <= fca_pkg::MASK_RST;
			reg_rdata <= 32'h0000_0000;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_r <= reg_wdata[fca_pkg::CTRL_W-1:0];
			if (wr_fresp)
				fresp_r <= reg_wdata[NF-1:0];
			if (wr_seq)
				seqpos_r <= reg_wdata[2:0];
			if (wr_mask)
				irq_mask_r <= reg_wdata[fca_pkg::IRQ_W-1:0];
			irq_stat_r <= irq_stat_nxt;
			reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
		end
	end
	////////////////////////////////////////////////////////////////
	// fault, shutdown, broadcast and restart control
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			fault_prev_r <= '0;
			shut_r <= 1'b0;
			bc_pend_r <= 1'b0;
			bc_cnt_r <= '0;
			ddc_prev_r <= 1'b1;
			rst_armed_r <= 1'b0;
			out_enable <= 1'b0;
			interdevice_bus_out <= 1'b0;
			interdevice_bus_oe_n <= 1'b1;
			fault_alert_line_out <= 1'b0;
			fault_alert_line_oe_n <= 1'b1;
			irq <= 1'b0;
		end
		else
		begin
			fault_prev_r <= fault_req;
			ddc_prev_r <= ddc_s;
			// shutdown wins over a restart in the same cycle
			if (local_shut || peer_shut)
				shut_r <= 1'b1; // RULE15 RULE16
			else if (rst_done)
				shut_r <= 1'b0; // RULE18
			rst_armed_r <= rst_go || (rst_armed_r && !(local_shut || peer_shut));
			// rail member waits for the rest of the rail
			bc_pend_r <= bcast_en && (local_shut || (bc_pend_r && shut_r)) && !bcast_go; // RULE17
			if (bcast_go)
				bc_cnt_r <= BC_WIN;
			else if (!bc_idle)
				bc_cnt_r <= bc_cnt_r - 1'b1;
			interdevice_bus_oe_n <= !(bcast_go || (bc_cnt_r > BC_GUARD + 1)); // RULE15
			out_enable <= ctrl_run && !(shut_r || local_shut || peer_shut);
			fault_alert_line_oe_n <= !(|(irq_stat_nxt & irq_mask_nxt)); // RULE12 RULE14
			irq <= |(irq_stat_nxt & irq_mask_nxt);
		end
	end
	////////////////////////////////////////////////////////////////
	// capture record freeze and block read pointer
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			frozen_r <= 1'b0;
			rd_ptr_r <= 5'h00;
		end
		else
		begin
			if (local_shut || cmd_recall)
				frozen_r <= 1'b1; // RULE6 RULE8
			else if (ctrl_run && !out_enable && !shut_r)
				frozen_r <= 1'b0;
			if (rd_data)
				rd_ptr_r <= (rd_ptr_r == LAST_BYTE) ? 5'h00 : rd_ptr_r + 1'b1; // RULE3
		end
	end
	////////////////////////////////////////////////////////////////
	// per-byte record storage in ram and non-volatile copy
	for (genvar i = 0; i < NB; i++)
	begin : g_rec
		always_ff @(posedge clk)
		begin
			if (reset)
			begin
				ram_r[i] <= 8'h00;
				nvm_r[i] <= 8'h00;
			end
			else
			begin
				if (cmd_recall)
					ram_r[i] <= nvm_r[i]; // RULE6
				else if (live_upd)
					ram_r[i] <= live_w[i*8 +: 8]; // RULE1
				if (nvm_done)
					nvm_r[i] <= ram_r[i]; // RULE7 RULE8
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// checks
	int nvm_cyc; // length of the current store
	always_ff @(posedge clk)
	begin
		if (reset || nvm_go)
			nvm_cyc <= 0;
		else if (nvm_busy)
			nvm_cyc <= nvm_cyc + 1;
	end
	property p_cap_off;
		@(posedge clk) disable iff (reset)
		!cap_en && (wr_cmd || local_shut) |=> !$rose(nvm_busy);
	endproperty
	a_cap_off: assert property (p_cap_off) else $error("store while capture off"); // RULE1 RULE19
	property p_store_enabled;
		@(posedge clk) disable iff (reset)
		cmd_store && out_enable && !local_shut |=> !$rose(nvm_busy);
	endproperty
	a_store_enabled: assert property (p_store_enabled) else $error("store while enabled"); // RULE7
	property p_auto_store;
		@(posedge clk) disable iff (reset)
		local_shut && cap_en && !nvm_busy |=> nvm_busy ##1 frozen_r;
	endproperty
	a_auto_store: assert property (p_auto_store) else $error("no store on shutdown"); // RULE8
	property p_retry_no_store;
		@(posedge clk) disable iff (reset)
		(|fault_new) && !local_shut && !wr_cmd |=> !$rose(nvm_busy);
	endproperty
	a_retry_no_store: assert property (p_retry_no_store) else $error("store on retry"); // RULE9
	property p_store_len;
		@(posedge clk) disable iff (reset)
		$fell(nvm_busy) |-> (nvm_cyc == NVM_SHORT_CYC || nvm_cyc == NVM_LONG_CYC);
	endproperty
	a_store_len: assert property (p_store_len) else $error("store length wrong"); // RULE10
	property p_recall;
		@(posedge clk) disable iff (reset)
		cmd_recall |=> ram_r[0] == $past(nvm_r[0]) && frozen_r;
	endproperty
	a_recall: assert property (p_recall) else $error("recall did not copy"); // RULE6
	property p_read_wrap;
		@(posedge clk) disable iff (reset)
		rd_data && rd_ptr_r == LAST_BYTE |=> rd_ptr_r == 5'h00;
	endproperty
	a_read_wrap: assert property (p_read_wrap) else $error("block read length"); // RULE3
	property p_alert;
		@(posedge clk) disable iff (reset)
		(|fault_new) && irq_mask_nxt[fca_pkg::IRQ_LOCAL] |=> !fault_alert_line_oe_n;
	endproperty
	a_alert: assert property (p_alert) else $error("alert not driven"); // RULE12
	property p_alert_hold;
		@(posedge clk) disable iff (reset)
		!fault_alert_line_oe_n && !wr_stat && !wr_mask |=> !fault_alert_line_oe_n;
	endproperty
	a_alert_hold: assert property (p_alert_hold) else $error("alert released early"); // RULE14
	property p_bcast;
		@(posedge clk) disable iff (reset)
		bcast_go |=> !interdevice_bus_oe_n && !out_enable;
	endproperty
	a_bcast: assert property (p_bcast) else $error("no broadcast"); // RULE15
	property p_rail_hold;
		@(posedge clk) disable iff (reset)
		local_shut && share_member && rail_others_up && bc_idle |=> interdevice_bus_oe_n;
	endproperty
	a_rail_hold: assert property (p_rail_hold) else $error("rail broadcast early"); // RULE17
	property p_peer;
		@(posedge clk) disable iff (reset)
		peer_shut |=> !out_enable && shut_r;
	endproperty
	a_peer: assert property (p_peer) else $error("peer shutdown missed"); // RULE16
	property p_rail_restart;
		@(posedge clk) disable iff (reset)
		rst_go && share_member |=> ##1 rst_done;
	endproperty
	a_rail_restart: assert property (p_rail_restart) else $error("rail restart late"); // RULE18
endmodule

// ---- verification/fca_peer.sv ----
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
// peer controller on the shared fault bus
module fca_peer #(
	parameter int LOW_CYC = 40 // length of one broadcast pulse
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic fire, // one-cycle request to broadcast
	input wire logic bus_in, // resolved bus level
	output logic drive_n, // low while this peer pulls the bus
	output logic [7:0] heard // falling edges made by others
);
	logic [7:0] cnt_r; // cycles left in own pulse
	logic last_r; // bus level one cycle ago
	////////////////////////////////////////////////////////////////
	// own pulse timing and count of foreign broadcasts
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cnt_r <= 8'h00;
			last_r <= 1'b1;
			heard <= 8'h00;
		end
		else
		begin
			last_r <= bus_in;
			// a new request restarts the pulse
			if (fire)
				cnt_r <= 8'(LOW_CYC);
			else if (cnt_r != 8'h00)
				cnt_r <= cnt_r - 8'h01;
			// only edges outside own pulse are foreign
			if (last_r && !bus_in && cnt_r == 8'h00)
				heard <= heard + 8'h01;
		end
	end
	// open drain: released bus floats up to the pull-up
	assign drive_n = (cnt_r == 8'h00);
endmodule

// ---- verification/fault_capture_alert_test.sv ----
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
// self-checking bench for the fault capture and alert block
module fault_capture_alert_test;
	localparam int NS = 20; // shortened plain store
	localparam int NL = 40; // shortened block-arranged store
	localparam int SQ = 10; // shortened restart step
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [7:0] fault_req = 8'h00;
	logic rail_others_up = 1'b0;
	logic peer_fire = 1'b0; // asks the peer to broadcast
	logic [7:0] rec [22]; // live bytes by record index
	logic [7:0] keep [22]; // bytes the record should hold
	logic bus_out, bus_oe_n, al_out, al_oe_n, out_enable, irq, peer_n;
	logic [7:0] heard; // broadcasts the peer has seen
	wire bus_w = (bus_oe_n | bus_out) & peer_n; // pulled-up shared bus
	wire alert_w = al_oe_n | al_out; // pulled-up alert line
	logic [31:0] exp_q [$]; // expected read data, oldest first
	string name_q [$]; // what each expected read is
	logic rd_d = 1'b0; // a read was taken at the last edge
	int fails = 0;
	int check_count = 0;
	int seed = 83;
	int n;
	fca_top #(.NVM_SHORT_CYC(NS), .NVM_LONG_CYC(NL), .SEQ_STEP_CYC(SQ)) u_dut (
		.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault_req(fault_req),
		.rail_others_up(rail_others_up), .mon_vin({rec[21], rec[20]}),
		.mon_vout({rec[19], rec[18]}), .mon_iavg({rec[17], rec[16]}),
		.mon_ipeak({rec[15], rec[14]}), .mon_duty({rec[13], rec[12]}),
		.mon_tint({rec[11], rec[10]}), .mon_text({rec[9], rec[8]}), .mon_fsw({rec[7], rec[6]}),
		.mon_st_vout(rec[5]), .mon_st_iout(rec[4]), .mon_st_in(rec[3]), .mon_st_temp(rec[2]),
		.mon_st_cml(rec[1]), .mon_st_mfr(rec[0]), .interdevice_bus_in(bus_w),
		.interdevice_bus_out(bus_out), .interdevice_bus_oe_n(bus_oe_n),
		.fault_alert_line_out(al_out), .fault_alert_line_oe_n(al_oe_n),
		.out_enable(out_enable), .irq(irq)
	);
	fca_peer #(.LOW_CYC(40)) u_peer (.clk(clk), .reset(reset), .fire(peer_fire),
		.bus_in(bus_w), .drive_n(peer_n), .heard(heard));
	always #12.5 clk = ~clk;
	////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// one comparison
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// register write, strobe left up for a back-to-back follower
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_rd <= 1'b0;
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
	endtask
	// register read, expectation queued for the monitor
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		exp_q.push_back(e);
		name_q.push_back(nm);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
	endtask
	// drop strobes and let k edges pass
	task automatic idle(input int k);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (k) @(posedge clk);
		#1;
	endtask
	// new live values; upd also makes them the expected record
	task automatic new_rec(input bit upd);
		logic [7:0] v;
		foreach (rec[i])
		begin
			v = 8'($random(seed));
			rec[i] <= v;
			if (upd)
				keep[i] = v;
		end
	endtask
	// read cnt record bytes from pointer zero onwards
	task automatic read_rec(input int cnt);
		for (int i = 0; i < cnt; i++)
			rd(fca_pkg::OFS_CAPDATA, {24'h0, keep[i % 22]}, "record byte");
		idle(2);
	endtask
	function automatic logic sig(input int w);
		return (w == 0) ? out_enable : bus_w;
	endfunction
	// bounded wait for out_enable (0) or the bus (1) to reach v
	task automatic wait_for(input int w, input logic v, input int mx, output int c);
		c = 0;
		while (sig(w) !== v)
		begin
			@(posedge clk);
			#1;
			c++;
			if (c > mx)
			begin
				fails++;
				$display("ERROR wait %0d expected %b seen %b", w, v, sig(w));
				stop_test();
			end
		end
	endtask
	// synchronous reset held for six edges
	task automatic do_reset;
		reset <= 1'b1;
		fault_req <= 8'h00;
		rail_others_up <= 1'b0;
		idle(6);
		reset <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	// read monitor: read data stand in the cycle after the strobe
	always @(posedge clk)
		rd_d <= reg_rd;
	always @(negedge clk)
	begin
		if (rd_d && exp_q.size() == 0)
		begin
			fails++;
			$display("ERROR read data expected none seen %h", reg_rdata);
		end
		else if (rd_d)
			chk(name_q.pop_front(), exp_q.pop_front(), reg_rdata);
	end
	// hang guard
	initial
	begin
		repeat (90000) @(posedge clk);
		fails++;
		$display("ERROR run time expected end seen limit");
		stop_test();
	end
	////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		foreach (rec[i])
			rec[i] = 8'h00;
		do_reset();
		// reset values and an unmapped place
		rd(fca_pkg::OFS_CTRL, 32'h0, "control");
		rd(fca_pkg::OFS_FRESP, 32'hff, "fault response");
		rd(fca_pkg::OFS_IRQ_MASK, 32'h0, "mask");
		wr(8'h20, 32'hffffffff);
		rd(8'h20, 32'h0, "unmapped");
		idle(2);
		chk("alert idle", 32'h1, alert_w);
		// capture disabled: command and shutdown fault store nothing
		wr(fca_pkg::OFS_CAPCMD, {24'h0, fca_pkg::CMD_STORE});
		fault_req <= 8'h01;
		idle(NS + 6);
		rd(fca_pkg::OFS_IRQ_STAT, 32'h1, "status off");
		do_reset();
		// live record read as one 22-byte block, then wrap
		new_rec(1);
		wr(fca_pkg::OFS_CTRL, 32'h02);
		idle(4);
		read_rec(44);
		// store at both lengths, output disabled
		for (int m = 0; m < 2; m++)
		begin
			wr(fca_pkg::OFS_CTRL, m ? 32'h42 : 32'h02);
			wr(fca_pkg::OFS_CAPCMD, {24'h0, fca_pkg::CMD_STORE});
			idle(1);
			rd(fca_pkg::OFS_STATUS, 32'h4, "store busy");
			idle((m ? NL : NS) - 4);
			rd(fca_pkg::OFS_STATUS, 32'h4, "store late");
			idle(3);
			rd(fca_pkg::OFS_STATUS, 32'h0, "store over");
			rd(fca_pkg::OFS_IRQ_STAT, 32'h4, "store done");
			wr(fca_pkg::OFS_IRQ_STAT, 32'h4);
		end
		// host recalls the stored record, then reads it
		new_rec(0);
		idle(3);
		wr(fca_pkg::OFS_CAPCMD, {24'h0, fca_pkg::CMD_RECALL});
		idle(2);
		read_rec(22);
		// refused store, retry fault, masking and clearing the alert
		do_reset();
		wr(fca_pkg::OFS_FRESP, 32'hfe);
		wr(fca_pkg::OFS_CTRL, 32'h07);
		idle(3);
		wr(fca_pkg::OFS_CAPCMD, {24'h0, fca_pkg::CMD_STORE});
		fault_req <= 8'h01;
		idle(NS + 6);
		chk("alert masked", 32'h1, alert_w);
		rd(fca_pkg::OFS_IRQ_STAT, 32'h9, "refused and retry");
		chk("retry broadcast", 32'h0, heard);
		wr(fca_pkg::OFS_IRQ_MASK, 32'hf);
		idle(2);
		chk("alert set", 32'h0, alert_w);
		chk("irq set", 32'h1, irq);
		rd(fca_pkg::OFS_IRQ_STAT, 32'h9, "alert source");
		wr(fca_pkg::OFS_IRQ_STAT, 32'h1);
		idle(2);
		chk("alert one left", 32'h0, alert_w);
		wr(fca_pkg::OFS_IRQ_STAT, 32'h8);
		idle(2);
		chk("alert cleared", 32'h1, alert_w);
		// shutdown fault: output off, broadcast, auto store, frozen record
		do_reset();
		new_rec(1);
		wr(fca_pkg::OFS_CTRL, 32'h07);
		wr(fca_pkg::OFS_IRQ_MASK, 32'h1);
		wait_for(0, 1'b1, 6, n);
		fault_req <= 8'h80;
		idle(2);
		chk("output shut", 32'h0, out_enable);
		chk("broadcast", 32'h0, bus_w);
		chk("alert fault", 32'h0, alert_w);
		new_rec(0);
		wait_for(1, 1'b1, 60, n);
		chk("broadcast length", 32'd39, n);
		chk("peer heard", 32'h1, heard);
		rd(fca_pkg::OFS_IRQ_STAT, 32'h5, "auto store");
		read_rec(22);
		// peer event: shut, restart after own order delay
		for (int s = 0; s < 4; s += 3)
		begin
			do_reset();
			wr(fca_pkg::OFS_CTRL, 32'h19);
			wr(fca_pkg::OFS_SEQPOS, s);
			wait_for(0, 1'b1, 6, n);
			peer_fire <= 1'b1;
			idle(1);
			peer_fire <= 1'b0;
			wait_for(0, 1'b0, 8, n);
			wait_for(1, 1'b1, 60, n);
			wait_for(0, 1'b1, (s + 1) * SQ + 10, n);
			chk("restart order", 32'h1, n >= (s + 1) * SQ);
			rd(fca_pkg::OFS_IRQ_STAT, 32'h2, "peer seen");
		end
		// share rail: broadcast only after the whole rail is down
		do_reset();
		rail_others_up <= 1'b1;
		wr(fca_pkg::OFS_CTRL, 32'h37);
		wr(fca_pkg::OFS_SEQPOS, 32'h3);
		wait_for(0, 1'b1, 6, n);
		fault_req <= 8'h01;
		idle(20);
		chk("rail still up", 32'h1, bus_w);
		rail_others_up <= 1'b0;
		wait_for(1, 1'b0, 6, n);
		fault_req <= 8'h00;
		wait_for(1, 1'b1, 60, n);
		chk("rail waits", 32'h0, out_enable);
		wait_for(0, 1'b1, 12, n);
		idle(2);
		stop_test();
	end
endmodule
